// ==== include/afcsf_pkg.sv ====
`default_nettype none
package afcsf_pkg;
	// Register offsets
	localparam logic [7:0] AFCSF_OFS_DELAY = 8'h2B;
	localparam logic [7:0] AFCSF_OFS_CFG = 8'h2C;
	localparam logic [7:0] AFCSF_OFS_K1LO = 8'h2D;
	localparam logic [7:0] AFCSF_OFS_K1HI = 8'h2E;
	localparam logic [7:0] AFCSF_OFS_STATUS = 8'h2F;
	// Field positions
	localparam int AFCSF_BIT_BLOCK = 6;
	localparam int AFCSF_BIT_RESTART = 5;
	localparam int AFCSF_FRZ_LSB = 2;
	localparam int AFCSF_START_LSB = 0;
	// Reset values and config write mask
	localparam logic [7:0] AFCSF_RST_DELAY = 8'h00;
	localparam logic [7:0] AFCSF_RST_CFG = 8'h00;
	localparam logic [7:0] AFCSF_RST_K1LO = 8'h00;
	localparam logic [3:0] AFCSF_RST_K1HI = 4'h0;
	localparam logic [7:0] AFCSF_CFG_MASK = 8'h7F;
	// Base period: predecimation strobes per delay tick
	localparam int AFCSF_PREDEC_DIV = 4;
	localparam logic [1:0] AFCSF_PREDEC_LAST = 2'(AFCSF_PREDEC_DIV - 1);

	typedef enum logic [2:0] {
		AFCSF_FRZ_STAY = 3'h0,
		AFCSF_FRZ_RSSI = 3'h1,
		AFCSF_FRZ_RECOG = 3'h2,
		AFCSF_FRZ_SYNC = 3'h3,
		AFCSF_FRZ_MANUAL = 3'h4
	} afcsf_frz_t;

	typedef enum logic [1:0] {
		AFCSF_START_OFF = 2'h0,
		AFCSF_START_DIRECT = 2'h1,
		AFCSF_START_RSSI = 2'h2,
		AFCSF_START_RECOG = 2'h3
	} afcsf_start_t;

	typedef enum logic [1:0] {
		AFCSF_ST_OFF = 2'b00,
		AFCSF_ST_WAIT = 2'b01,
		AFCSF_ST_RUN = 2'b10,
		AFCSF_ST_FROZEN = 2'b11
	} afcsf_state_t;

	typedef struct packed {
		logic rssi;
		logic recog;
		logic sync;
		logic manual;
		logic chan_change;
		logic slot_start;
		logic hold_exit;
	} afcsf_evt_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} afcsf_bus_t;
endpackage
`default_nettype wire

// ==== src/afcsf_tick_div.sv ====
`timescale 1ns/10ps
`default_nettype none
module afcsf_tick_div
	import afcsf_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Strobes
	input wire logic clear_i,
	input wire logic predec_stb_i,
	output logic tick_o
);
	logic [1:0] cnt_reg;
	wire last = (cnt_reg == AFCSF_PREDEC_LAST);
	assign tick_o = predec_stb_i && last && !clear_i;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i || (ce_i && clear_i)) begin
			cnt_reg <= 2'h0;
		end else if (ce_i && predec_stb_i) begin
			cnt_reg <= last ? 2'h0 : cnt_reg + 2'h1;
		end
	end
endmodule
`default_nettype wire

// ==== src/afcsf_delay_cnt.sv ====
`timescale 1ns/10ps
`default_nettype none
module afcsf_delay_cnt
	import afcsf_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Control
	input wire logic load_i,
	input wire logic [7:0] ratio_i,
	input wire logic tick_i,
	// Status
	output logic busy_o,
	output logic done_o
);
	logic [7:0] cnt_reg;
	logic busy_reg;
	wire last = (cnt_reg == 8'h01);
	assign busy_o = busy_reg;
	assign done_o = busy_reg && tick_i && last;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			cnt_reg <= 8'h00;
			busy_reg <= 1'b0;
		end else if (ce_i) begin
			if (load_i) begin
				cnt_reg <= ratio_i;
				busy_reg <= (ratio_i != 8'h00);
			end else if (busy_reg && tick_i) begin
				cnt_reg <= cnt_reg - 8'h01;
				busy_reg <= !last;
			end
		end
	end
endmodule
`default_nettype wire

// ==== src/afcsf_ctrl.sv ====
// Notes on behaviour
// - 8-bit freeze delay ratio sets base periods between trigger and freeze.
// - Delay base period is predecimation strobe divided by four.
// - Block bit set suspends updates while amplitude-keyed input is low.
// - Restart bit restarts loop on channel change and on slot start while self polling.
// - Restart bit also restarts loop on hold exit in slave run mode when hold init enabled.
// - Freeze codes 000 run, 001 strength plus delay, 010 recognition plus delay.
// - Freeze code 011 freezes after symbol sync plus delay.
// - Freeze code 100 freezes on manual command; 101 to 111 unused.
// - Start codes 00 off, 01 direct, 10 strength, 11 recognition.
// - Twelve-bit K1 is high nibble joined with low byte.
`timescale 1ns/10ps
`default_nettype none
module afcsf_ctrl
	import afcsf_pkg::*;
(
	// Clock, reset, enable
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// Receiver events
	input wire logic predec_stb_i,
	input wire logic rssi_evt_i,
	input wire logic recog_evt_i,
	input wire logic sync_evt_i,
	input wire logic manual_freeze_command_bit_i,
	input wire logic chan_change_i,
	input wire logic slot_start_i,
	input wire logic self_polling_i,
	input wire logic slave_run_i,
	input wire logic pll_hold_init_enable_i,
	input wire logic hold_exit_i,
	input wire logic ask_low_i,
	// Loop control
	output logic afc_update_en_o,
	output logic afc_restart_o,
	output logic afc_frozen_o,
	output logic [11:0] loop_gain_one_o
);
	////////////////////////////////////////////////////////////////////////
	// Registers
	logic [7:0] freeze_delay_reg;
	logic [7:0] freeze_start_config;
	logic [7:0] loop_gain_one_low_reg;
	logic [3:0] loop_gain_one_high_reg;
	logic [7:0] rdata_reg;
	afcsf_state_t state_reg, state_next;
	logic restart_reg;
	logic update_reg;
	afcsf_evt_t evt;
	logic tick;
	logic dly_busy;
	logic dly_done;

	assign evt = '{rssi: rssi_evt_i, recog: recog_evt_i, sync: sync_evt_i,
		manual: manual_freeze_command_bit_i, chan_change: chan_change_i,
		slot_start: slot_start_i, hold_exit: hold_exit_i};

	wire wr_delay = wr_i && (addr_i == AFCSF_OFS_DELAY);
	wire wr_cfg = wr_i && (addr_i == AFCSF_OFS_CFG);
	wire wr_k1lo = wr_i && (addr_i == AFCSF_OFS_K1LO);
	wire wr_k1hi = wr_i && (addr_i == AFCSF_OFS_K1HI);

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			freeze_delay_reg <= AFCSF_RST_DELAY;
			freeze_start_config <= AFCSF_RST_CFG;
			loop_gain_one_low_reg <= AFCSF_RST_K1LO;
			loop_gain_one_high_reg <= AFCSF_RST_K1HI;
		end else if (ce_i) begin
			if (wr_delay) begin
				freeze_delay_reg <= wdata_i;
			end
			if (wr_cfg) begin
				freeze_start_config <= wdata_i & AFCSF_CFG_MASK;
			end
			if (wr_k1lo) begin
				loop_gain_one_low_reg <= wdata_i;
			end
			if (wr_k1hi) begin
				loop_gain_one_high_reg <= wdata_i[3:0];
			end
		end
	end

	// Field decode
	wire amplitude_low_block = freeze_start_config[AFCSF_BIT_BLOCK];
	wire restart_on_channel_change = freeze_start_config[AFCSF_BIT_RESTART];
	wire [2:0] freeze_select = freeze_start_config[AFCSF_FRZ_LSB +: 3];
	wire [1:0] start_select = freeze_start_config[AFCSF_START_LSB +: 2];

	assign loop_gain_one_o = {loop_gain_one_high_reg, loop_gain_one_low_reg};

	////////////////////////////////////////////////////////////////////////
	// Read port
	wire [7:0] status_word = {4'h0, 1'b0, dly_busy, state_reg};
	logic [7:0] rd_mux;
	always_comb begin
		case (addr_i)
			AFCSF_OFS_DELAY: rd_mux = freeze_delay_reg;
			AFCSF_OFS_CFG: rd_mux = freeze_start_config;
			AFCSF_OFS_K1LO: rd_mux = loop_gain_one_low_reg;
			AFCSF_OFS_K1HI: rd_mux = {4'h0, loop_gain_one_high_reg};
			AFCSF_OFS_STATUS: rd_mux = status_word;
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			rdata_reg <= 8'h00;
		end else if (ce_i) begin
			rdata_reg <= rd_i ? rd_mux : 8'h00;
		end
	end
	assign rdata_o = rdata_reg;

	////////////////////////////////////////////////////////////////////////
	// Event selection
	// channel change and self-polling slot start
	wire restart_a = restart_on_channel_change &&
		(evt.chan_change || (self_polling_i && evt.slot_start));
	// hold exit in slave run mode
	wire restart_b = restart_on_channel_change && slave_run_i &&
		pll_hold_init_enable_i && evt.hold_exit;
	wire restart_now = restart_a || restart_b;

	logic start_hit;
	always_comb begin
		case (start_select)
			AFCSF_START_DIRECT: start_hit = 1'b1;
			AFCSF_START_RSSI: start_hit = evt.rssi;
			AFCSF_START_RECOG: start_hit = evt.recog;
			default: start_hit = 1'b0;
		endcase
	end

	logic frz_hit;
	logic frz_delayed;
	always_comb begin
		case (freeze_select)
			AFCSF_FRZ_RSSI: frz_hit = evt.rssi;
			AFCSF_FRZ_RECOG: frz_hit = evt.recog;
			AFCSF_FRZ_SYNC: frz_hit = evt.sync;
			AFCSF_FRZ_MANUAL: frz_hit = evt.manual;
			default: frz_hit = 1'b0;
		endcase
	end
	assign frz_delayed = (freeze_select != AFCSF_FRZ_MANUAL);

	////////////////////////////////////////////////////////////////////////
	// Delay timing
	wire dly_arm = (state_reg == AFCSF_ST_RUN) && frz_hit && frz_delayed &&
		!dly_busy && (freeze_delay_reg != 8'h00) && !restart_now;
	wire dly_clear = restart_now || (state_reg != AFCSF_ST_RUN);

	afcsf_tick_div u_tick (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.clear_i(dly_arm),
		.predec_stb_i(predec_stb_i),
		.tick_o(tick)
	);

	afcsf_delay_cnt u_delay (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i || (ce_i && dly_clear)),
		.ce_i(ce_i),
		.load_i(dly_arm),
		.ratio_i(freeze_delay_reg),
		.tick_i(tick),
		.busy_o(dly_busy),
		.done_o(dly_done)
	);

	// zero ratio freezes on the event itself
	wire frz_now = (frz_hit && (!frz_delayed || freeze_delay_reg == 8'h00)) ||
		dly_done;

	////////////////////////////////////////////////////////////////////////
	// Start/freeze state machine
	always_comb begin
		case (state_reg)
			AFCSF_ST_OFF: state_next = AFCSF_ST_WAIT;
			AFCSF_ST_WAIT: state_next = start_hit ? AFCSF_ST_RUN : AFCSF_ST_WAIT;
			AFCSF_ST_RUN: state_next = frz_now ? AFCSF_ST_FROZEN : AFCSF_ST_RUN;
			AFCSF_ST_FROZEN: state_next = AFCSF_ST_FROZEN;
			default: state_next = AFCSF_ST_OFF;
		endcase
		if (start_select == AFCSF_START_OFF) begin
			state_next = AFCSF_ST_OFF;
		end else if (restart_now) begin
			state_next = AFCSF_ST_WAIT;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			state_reg <= AFCSF_ST_OFF;
			restart_reg <= 1'b0;
		end else if (ce_i) begin
			state_reg <= state_next;
			restart_reg <= restart_now;
		end
	end

	wire block_now = amplitude_low_block && ask_low_i;
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			update_reg <= 1'b0;
		end else if (ce_i) begin
			update_reg <= (state_next == AFCSF_ST_RUN) && !block_now;
		end
	end

	assign afc_update_en_o = update_reg;
	assign afc_restart_o = restart_reg;
	assign afc_frozen_o = (state_reg == AFCSF_ST_FROZEN);

	////////////////////////////////////////////////////////////////////////
	// Checks
	// low amplitude block
	a_block_ask_low: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		ce_i && amplitude_low_block && ask_low_i |=> !afc_update_en_o)
		else $error("update not blocked during low amplitude");
	a_restart_chan: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		ce_i && restart_on_channel_change && chan_change_i |=> afc_restart_o)
		else $error("no restart on channel change");
	a_no_restart_off: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		ce_i && !restart_on_channel_change |=> !afc_restart_o)
		else $error("restart while disabled");
	a_restart_wait: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		ce_i && restart_now && start_select != AFCSF_START_OFF
		|=> state_reg == AFCSF_ST_WAIT && !afc_update_en_o)
		else $error("restart did not re-enter wait");
	a_restart_hold: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		ce_i && restart_on_channel_change && slave_run_i &&
		pll_hold_init_enable_i && hold_exit_i |=> afc_restart_o)
		else $error("no restart on hold exit");
	a_stay_on: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		ce_i && freeze_select == AFCSF_FRZ_STAY && state_reg == AFCSF_ST_RUN
		&& !restart_now && start_select != AFCSF_START_OFF
		|=> state_reg == AFCSF_ST_RUN)
		else $error("frozen with freeze disabled");
	a_manual_frz: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		ce_i && freeze_select == AFCSF_FRZ_MANUAL && state_reg == AFCSF_ST_RUN
		&& manual_freeze_command_bit_i && !restart_now
		&& start_select != AFCSF_START_OFF |=> afc_frozen_o)
		else $error("manual freeze missed");
	a_unused_frz: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		ce_i && freeze_select > 3'h4 && state_reg == AFCSF_ST_RUN &&
		!dly_busy |=> !afc_frozen_o)
		else $error("unused freeze code froze the loop");
	a_start_off: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		ce_i && start_select == AFCSF_START_OFF |=> state_reg == AFCSF_ST_OFF)
		else $error("loop not off");
	a_start_direct: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		ce_i && start_select == AFCSF_START_DIRECT &&
		state_reg == AFCSF_ST_WAIT && !restart_now |=> state_reg == AFCSF_ST_RUN)
		else $error("direct start did not run");
	a_k1_join: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		ce_i && wr_i && addr_i == AFCSF_OFS_K1LO
		|=> loop_gain_one_o[7:0] == $past(wdata_i))
		else $error("K1 low byte not taken");
	a_rst_zero: assert property (
		@(posedge ref_clk_i)
		rst_i |=> freeze_delay_reg == 8'h00 && freeze_start_config == 8'h00 &&
		loop_gain_one_low_reg == 8'h00 && !afc_update_en_o)
		else $error("register not cleared by reset");
	a_zero_delay: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		ce_i && state_reg == AFCSF_ST_RUN && frz_hit && !restart_now &&
		freeze_delay_reg == 8'h00 && start_select != AFCSF_START_OFF
		|=> afc_frozen_o)
		else $error("zero delay freeze late");
	a_delay_hold: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		ce_i && dly_arm && freeze_delay_reg != 8'h00 |=> !afc_frozen_o)
		else $error("freeze before delay");
	a_delay_frz: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		ce_i && dly_done && state_reg == AFCSF_ST_RUN && !restart_now &&
		start_select != AFCSF_START_OFF |=> afc_frozen_o)
		else $error("delayed freeze missed");
	logic [9:0] chk_left_reg;
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			chk_left_reg <= 10'h000;
		end else if (ce_i && dly_arm) begin
			chk_left_reg <= {freeze_delay_reg, 2'b00};
		end else if (ce_i && predec_stb_i && dly_busy) begin
			chk_left_reg <= chk_left_reg - 10'h001;
		end
	end
	a_delay_span: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		ce_i && dly_done |-> chk_left_reg == 10'h001)
		else $error("delay not four strobes per step");
	c_direct_run: cover property (@(posedge ref_clk_i) disable iff (rst_i)
		state_reg == AFCSF_ST_WAIT ##1 state_reg == AFCSF_ST_RUN);
	c_delay_frz: cover property (@(posedge ref_clk_i) disable iff (rst_i)
		dly_done ##1 afc_frozen_o);
	c_restart: cover property (@(posedge ref_clk_i) disable iff (rst_i)
		afc_frozen_o && restart_now);
	c_manual_frz: cover property (@(posedge ref_clk_i) disable iff (rst_i)
		freeze_select == AFCSF_FRZ_MANUAL ##1 afc_frozen_o);
	c_blocked: cover property (@(posedge ref_clk_i) disable iff (rst_i)
		amplitude_low_block && ask_low_i && state_reg == AFCSF_ST_RUN);
endmodule
`default_nettype wire

// ==== sim/afcsf_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb
	import afcsf_pkg::*;
();
	////////////////////////////////////////////////////////////////
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	// Events: strength, recog, sync, manual, chan, slot, hold, predec
	logic [7:0] ev = 8'h00;
	// Levels: self polling, slave run, hold init, ask low
	logic [3:0] lv = 4'h0;
	logic [7:0] rdata_o;
	logic upd;
	logic restart;
	logic frz;
	logic [11:0] gain;
	int err_total = 0;
	int cmp_count = 0;

	always #10 ref_clk_i = ~ref_clk_i;

	afcsf_ctrl dut_u (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .predec_stb_i(ev[7]), .rssi_evt_i(ev[0]),
		.recog_evt_i(ev[1]), .sync_evt_i(ev[2]),
		.manual_freeze_command_bit_i(ev[3]), .chan_change_i(ev[4]),
		.slot_start_i(ev[5]), .hold_exit_i(ev[6]),
		.self_polling_i(lv[0]), .slave_run_i(lv[1]),
		.pll_hold_init_enable_i(lv[2]), .ask_low_i(lv[3]),
		.afc_update_en_o(upd), .afc_restart_o(restart),
		.afc_frozen_o(frz), .loop_gain_one_o(gain)
	);
	////////////////////////////////////////////////////////////////
	task automatic final_report;
		$display("errors=%0d checks=%0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic see(input int n);
		repeat (n) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		@(negedge ref_clk_i);
		chk(rdata_o, e);
	endtask

	task automatic pulse(input int i);
		@(posedge ref_clk_i);
		ev[i] <= 1'b1;
		@(posedge ref_clk_i);
		ev[i] <= 1'b0;
	endtask

	task automatic setlv(input logic [3:0] v);
		@(posedge ref_clk_i);
		lv <= v;
	endtask

	// Manual freeze, then one restart cause
	task automatic frz_cause(input int i, input logic e);
		see(2);
		pulse(3);
		@(posedge ref_clk_i);
		ev[i] <= 1'b1;
		@(posedge ref_clk_i);
		ev[i] <= 1'b0;
		@(negedge ref_clk_i);
		chk(restart, e);
		see(3);
		chk(frz, !e);
		chk(upd, e);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_regs;
		rd(AFCSF_OFS_DELAY, 8'h00);
		rd(AFCSF_OFS_CFG, 8'h00);
		rd(AFCSF_OFS_K1LO, 8'h00);
		chk(gain, 12'h000);
		chk(upd, 1'b0);
		wr(AFCSF_OFS_K1LO, 8'hA5);
		wr(AFCSF_OFS_K1HI, 8'hFC);
		see(1);
		chk(gain, 12'hCA5);
		wr(AFCSF_OFS_CFG, 8'hFF);
		rd(AFCSF_OFS_CFG, 8'h7F);
		wr(AFCSF_OFS_DELAY, 8'h96);
		wr(8'h40, 8'h11);
		rd(AFCSF_OFS_DELAY, 8'h96);
		rd(8'h40, 8'h00);
		rd(AFCSF_OFS_K1LO, 8'hA5);
		rd(AFCSF_OFS_K1HI, 8'h0C);
		wr(AFCSF_OFS_CFG, 8'h00);
	endtask

	task automatic t_start;
		pulse(0);
		pulse(1);
		see(2);
		chk(upd, 1'b0);
		for (int s = 2; s < 4; s++) begin
			wr(AFCSF_OFS_CFG, 8'h00);
			wr(AFCSF_OFS_CFG, 8'(s));
			pulse(3 - s);
			see(2);
			chk(upd, 1'b0);
			pulse(s - 2);
			see(2);
			chk(upd, 1'b1);
		end
	endtask

	task automatic t_freeze;
		wr(AFCSF_OFS_DELAY, 8'h02);
		for (int f = 1; f < 4; f++) begin
			wr(AFCSF_OFS_CFG, 8'h00);
			wr(AFCSF_OFS_CFG, 8'((f << 2) | 1));
			see(2);
			pulse(f % 3);
			repeat (8) pulse(7);
			see(2);
			chk(frz, 1'b0);
			pulse(f - 1);
			repeat (7) pulse(7);
			see(2);
			chk(frz, 1'b0);
			chk(upd, 1'b1);
			pulse(7);
			see(4);
			chk(frz, 1'b1);
			chk(upd, 1'b0);
		end
	endtask

	task automatic t_zero;
		wr(AFCSF_OFS_DELAY, 8'h00);
		for (int f = 1; f < 8; f++) begin
			wr(AFCSF_OFS_CFG, 8'h00);
			wr(AFCSF_OFS_CFG, 8'((f << 2) | 1));
			see(2);
			for (int i = 0; i < 4; i++) begin
				if (f > 4 || i == f - 1) begin
					pulse(i);
				end
			end
			see(0);
			chk(frz, f < 5);
		end
	endtask

	task automatic t_block;
		wr(AFCSF_OFS_CFG, 8'h41);
		see(2);
		setlv(4'h8);
		see(2);
		chk(upd, 1'b0);
		setlv(4'h0);
		see(2);
		chk(upd, 1'b1);
		wr(AFCSF_OFS_CFG, 8'h01);
		setlv(4'h8);
		see(2);
		chk(upd, 1'b1);
		setlv(4'h0);
	endtask

	task automatic t_restart;
		wr(AFCSF_OFS_CFG, 8'h31);
		frz_cause(4, 1'b1);
		frz_cause(5, 1'b0);
		setlv(4'h1);
		frz_cause(5, 1'b1);
		setlv(4'h3);
		frz_cause(6, 1'b0);
		setlv(4'h4);
		frz_cause(6, 1'b0);
		setlv(4'h6);
		frz_cause(6, 1'b1);
		wr(AFCSF_OFS_CFG, 8'h11);
		setlv(4'h7);
		for (int i = 4; i < 7; i++) begin
			frz_cause(i, 1'b0);
		end
	endtask

	task automatic t_reset;
		wr(AFCSF_OFS_DELAY, 8'h33);
		@(posedge ref_clk_i);
		ce_i <= 1'b0;
		wr(AFCSF_OFS_K1LO, 8'h5A);
		@(posedge ref_clk_i);
		ce_i <= 1'b1;
		rd(AFCSF_OFS_K1LO, 8'hA5);
		@(posedge ref_clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		see(0);
		chk(gain, 12'h000);
		chk(frz, 1'b0);
		chk(upd, 1'b0);
		rd(AFCSF_OFS_DELAY, 8'h00);
		rd(AFCSF_OFS_CFG, 8'h00);
		rd(AFCSF_OFS_K1LO, 8'h00);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		t_regs;
		t_start;
		t_freeze;
		t_zero;
		t_block;
		t_restart;
		t_reset;
		final_report;
	end

	initial begin
		repeat (20000) @(posedge ref_clk_i);
		err_total++;
		final_report;
	end
endmodule
`default_nettype wire
